// [shared/cssw_defines.svh]
// constants for the clock source switch: register offsets, field positions, resets
// assumes an 8-bit plain register port and a 100 MHz system clock
`ifndef CSSW_DEFINES_SVH
`define CSSW_DEFINES_SVH
// ****************************************************************
// register map
// ****************************************************************
`define CSSW_OFS_TRIM      8'h38
`define CSSW_OFS_STATUS    8'h3C
`define CSSW_OFS_OPTION    8'h40
// ****************************************************************
// fields and reset values
// ****************************************************************
`define CSSW_TRIM_RST      8'h80
`define CSSW_STAT_REQ      0
`define CSSW_STAT_ENG      1
`define CSSW_OPT_SEL_LO    0
`define CSSW_OPT_PIN_OE    2
`define CSSW_OPT_RST       8'h00
// ****************************************************************
// timing
// ****************************************************************
`define CSSW_CLK_MHZ       100
`define CSSW_INT_HALF_BASE 9'h010
`define CSSW_CONFIRM_EDGES 2'h2
`endif

// [shared/cssw_pkg.sv]
// types shared by the clock source switch
// assumes the defines header is compiled alongside
package cssw_pkg;
  typedef enum logic [1:0] {
    CSSW_SEL_INT  = 2'h0,
    CSSW_SEL_EXT  = 2'h1,
    CSSW_SEL_RC   = 2'h2,
    CSSW_SEL_XTAL = 2'h3
  } cssw_sel_t;
  typedef enum {ST_INT, ST_CONFIRM, ST_ALIGN, ST_ENGAGED} cssw_state_t;
  typedef struct packed {
    logic out;
    logic oe;
  } cssw_pin_t;
endpackage

// [logic/cssw_clock_source_switch.sv]
// clock source switch: internal trimmable oscillator, external sources,
// one-way glitch-free switch, trim register and clock output pin control
// assumes all inputs are synchronous to clk; the external clock is sampled
// at 100 MHz, so it must run well below 50 MHz
//
// Overview of operation
// - source clock follows the currently selected oscillator
// - half-rate clock toggles on each source clock rising edge
// - internal oscillator drives the clocks after reset until the switch engages
// - eight bit trim register; larger value lengthens internal period
// - reset loads the trim register with midpoint 0x80
// - two-bit select: internal, external clock, RC, crystal
// - external select makes input pin a clock input; crystal drives output pin
// - two external rising edges confirm activity before switching
// - clock outputs move to the external clock without glitch
// - engaged flag set first, internal oscillator stopped afterwards
// - internal oscillator returns only on reset; no automatic fallback
// - request bit read/write, reset low, ignored in monitor bypass
// - external clock mode uses input pin directly as source clock
// - crystal mode pin is inverting output; external clock mode pin is port
// - internal or RC: pin is port when enable bit low, else source clock
// - oscillator enable gates whichever oscillator is active
// - stop mode halts both generated clocks; wait mode leaves them running
`include "cssw_defines.svh"
`timescale 1ns/10ps
module cssw_clock_source_switch (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              clock_input_pin,
  input  wire cssw_pkg::cssw_pin_t port_bit_four,
  output cssw_pkg::cssw_pin_t    clock_output_pin,
  output logic                   clock_input_is_clock,
  input  wire logic              oscillator_enable,
  input  wire logic              stop_mode,
  input  wire logic              monitor_bypass,
  output logic                   source_clock_out,
  output logic                   half_rate_clock_out,
  output logic                   external_engaged_flag
);
  import cssw_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [8:0] half_of(input logic [7:0] trim);
    half_of = `CSSW_INT_HALF_BASE + {1'b0, trim};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  trim_reg;
  logic        req_reg;
  cssw_sel_t   sel_reg;
  logic        pin_oe_reg;
  logic [7:0]  rdata_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_reg <= `CSSW_TRIM_RST;
    end else if (reg_wr && hit(reg_addr, `CSSW_OFS_TRIM)) begin
      trim_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `CSSW_OFS_STATUS) && !monitor_bypass) begin
      req_reg <= reg_wdata[`CSSW_STAT_REQ];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_reg    <= CSSW_SEL_INT;
      pin_oe_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `CSSW_OFS_OPTION)) begin
      sel_reg    <= cssw_sel_t'(reg_wdata[`CSSW_OPT_SEL_LO +: 2]);
      pin_oe_reg <= reg_wdata[`CSSW_OPT_PIN_OE];
    end
  end

  // ****************************************************************
  // switch sequencer
  // ****************************************************************
  cssw_state_t state_reg;
  cssw_state_t state_next;
  logic        req_q_reg;
  logic        ext_q_reg;
  logic        ext_q2_reg;
  logic        ext_rise;
  logic [1:0]  edge_cnt_reg;
  logic        engaged_reg;
  logic        int_stop_reg;
  logic        int_lvl_reg;
  logic        go_ext;

  // request passes one more flop so counting starts from a settled level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q_reg <= 1'b0;
    end else begin
      req_q_reg <= req_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= clock_input_pin;
    end
  end

  // second sample of the pin marks the start of an external low phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_q2_reg <= 1'b0;
    end else begin
      ext_q2_reg <= ext_q_reg;
    end
  end

  assign ext_rise = clock_input_pin && !ext_q_reg;
  // switch only as the external low phase begins while the internal clock is low;
  // switching late in that phase would leave a runt low pulse on the outputs
  assign go_ext = (state_reg == ST_ALIGN) && !int_lvl_reg && ext_q2_reg && !ext_q_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INT: begin
        if (req_q_reg && sel_reg != CSSW_SEL_INT) begin
          state_next = ST_CONFIRM;
        end
      end
      ST_CONFIRM: begin
        if (!req_q_reg) begin
          state_next = ST_INT;
        end else if (edge_cnt_reg == `CSSW_CONFIRM_EDGES) begin
          state_next = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (go_ext) begin
          state_next = ST_ENGAGED;
        end
      end
      ST_ENGAGED: begin
        state_next = ST_ENGAGED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_INT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != ST_CONFIRM) begin
      edge_cnt_reg <= 2'h0;
    end else if (ext_rise && edge_cnt_reg != `CSSW_CONFIRM_EDGES) begin
      edge_cnt_reg <= edge_cnt_reg + 2'h1;
    end
  end

  // flag first, then the internal oscillator stops one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      engaged_reg  <= 1'b0;
      int_stop_reg <= 1'b0;
    end else begin
      engaged_reg  <= engaged_reg || go_ext;
      int_stop_reg <= engaged_reg;
    end
  end

  // ****************************************************************
  // internal oscillator model and clock outputs
  // ****************************************************************
  logic [8:0] int_cnt_reg;
  logic       run;
  logic       use_ext;
  logic       src_next;
  logic       half_reg;
  logic       src_reg;

  assign run = oscillator_enable && !stop_mode;

  always_ff @(posedge clk) begin
    if (!rst_n || int_stop_reg || !run) begin
      int_cnt_reg <= 9'h000;
      int_lvl_reg <= 1'b0;
    end else if (int_cnt_reg >= half_of(trim_reg) - 9'h001) begin
      int_cnt_reg <= 9'h000;
      int_lvl_reg <= !int_lvl_reg;
    end else begin
      int_cnt_reg <= int_cnt_reg + 9'h001;
    end
  end

  assign use_ext  = engaged_reg || go_ext;
  assign src_next = run && (use_ext ? ext_q_reg : int_lvl_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_reg  <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      if (src_next && !src_reg) begin
        half_reg <= !half_reg;
      end
    end
  end

  // ****************************************************************
  // pin control and read port
  // ****************************************************************
  cssw_pin_t pin_reg;
  logic      in_clk_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_reg    <= '0;
      in_clk_reg <= 1'b0;
    end else begin
      in_clk_reg <= (sel_reg != CSSW_SEL_INT);
      unique case (sel_reg)
        CSSW_SEL_XTAL: pin_reg <= cssw_pin_t'{out: !clock_input_pin, oe: 1'b1};
        CSSW_SEL_EXT:  pin_reg <= port_bit_four;
        CSSW_SEL_INT,
        CSSW_SEL_RC:   pin_reg <= pin_oe_reg ? cssw_pin_t'{out: src_next, oe: 1'b1}
                                             : port_bit_four;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd) begin
      rdata_reg <= 8'h00;
    end else if (hit(reg_addr, `CSSW_OFS_TRIM)) begin
      rdata_reg <= trim_reg;
    end else if (hit(reg_addr, `CSSW_OFS_STATUS)) begin
      rdata_reg <= {6'h00, engaged_reg, req_reg};
    end else if (hit(reg_addr, `CSSW_OFS_OPTION)) begin
      rdata_reg <= {5'h00, pin_oe_reg, sel_reg};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign clock_output_pin      = pin_reg;
  assign clock_input_is_clock  = in_clk_reg;
  assign source_clock_out      = src_reg;
  assign half_rate_clock_out   = half_reg;
  assign external_engaged_flag = engaged_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_confirmed;
    state_reg == ST_CONFIRM && edge_cnt_reg == `CSSW_CONFIRM_EDGES && req_q_reg;
  endsequence
  sequence s_aligning;
    state_reg == ST_ALIGN;
  endsequence

  trim_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> trim_reg == `CSSW_TRIM_RST) else $error("trim not at midpoint");
  half_toggle_a: assert property ($rose(src_reg) |-> half_reg != $past(half_reg))
    else $error("half-rate clock missed a toggle");
  int_follow_a: assert property (!$past(use_ext) |-> src_reg == ($past(run) && $past(int_lvl_reg)))
    else $error("source clock not following internal");
  confirm_then_align_a: assert property (s_confirmed |=> s_aligning)
    else $error("no align after two edges");
  engage_needs_edges_a: assert property ($rose(engaged_reg) |-> $past(state_reg == ST_ALIGN))
    else $error("engaged without confirmation");
  switch_low_a: assert property ($rose(engaged_reg) |-> !src_reg)
    else $error("switch not at low level");
  flag_before_stop_a: assert property ($rose(int_stop_reg) |-> $past(engaged_reg, 1))
    else $error("internal stopped before flag");
  no_fallback_a: assert property (engaged_reg |=> engaged_reg && state_reg == ST_ENGAGED)
    else $error("fell back to internal");
  monitor_ignore_a: assert property (reg_wr && monitor_bypass |=> $stable(req_reg))
    else $error("request written in monitor bypass");
  stop_gate_a: assert property (!run |=> !src_reg ##1 !src_reg || !$past(!run))
    else $error("clock runs in stop");
  ext_pin_a: assert property (sel_reg == CSSW_SEL_EXT && $stable(sel_reg) |=>
    clock_output_pin == $past(port_bit_four)) else $error("pin not port in ext mode");
  xtal_pin_a: assert property (sel_reg == CSSW_SEL_XTAL && $stable(sel_reg) |=>
    clock_output_pin.oe && clock_output_pin.out == !$past(clock_input_pin))
    else $error("crystal pin not inverting");
  ext_low_span_a: assert property ($rose(engaged_reg) |-> !ext_q_reg && !src_reg)
    else $error("switch not at start of external low");
  in_clk_a: assert property (sel_reg != CSSW_SEL_INT |=> clock_input_is_clock)
    else $error("input pin not made a clock input");
  pin_clock_a: assert property ((sel_reg == CSSW_SEL_INT || sel_reg == CSSW_SEL_RC)
    && pin_oe_reg |=> clock_output_pin.oe && clock_output_pin.out == source_clock_out)
    else $error("pin not carrying source clock");
  trim_hold_a: assert property (!reg_wr |=> $stable(trim_reg))
    else $error("trim changed without a write");
endmodule

// [dv/cssw_siu_model.sv]
// system integration unit model: gates the oscillator, counts clock edges
// assumes the generated clocks are registered to clk
`timescale 1ns/10ps
module cssw_siu_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        source_clock_out,
  input  wire logic        half_rate_clock_out,
  input  wire logic        halt_osc,
  input  wire logic        stop_req,
  input  wire logic        clear,
  output logic             oscillator_enable,
  output logic             stop_mode,
  output logic [15:0]      src_edges,
  output logic [15:0]      half_edges
);
  logic src_q;
  logic half_q;
  // ********
  // low-power requests, held as levels
  // ********
  always_ff @(posedge clk) begin
    oscillator_enable <= ~halt_osc;
    stop_mode         <= stop_req;
  end
  // ********
  // edge counters; sampled at clk, so clocks must stay well below 50 MHz
  // ********
  always_ff @(posedge clk) begin
    src_q  <= source_clock_out;
    half_q <= half_rate_clock_out;
    if (!rst_n || clear) begin
      src_edges  <= 16'h0000;
      half_edges <= 16'h0000;
    end else begin
      src_edges  <= src_edges + 16'(source_clock_out & ~src_q);
      half_edges <= half_edges + 16'(half_rate_clock_out & ~half_q);
    end
  end
endmodule

// [dv/test_clock_source_switch.sv]
// testbench for the clock source switch: register calls plus clock checks
// assumes the design and the unit model share one 100 MHz clock
`include "cssw_defines.svh"
`timescale 1ns/10ps
module test_clock_source_switch;
  import cssw_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, clock_input_pin, monitor_bypass;
  logic halt_osc, stop_req, clear, ext_run, track, armed, src_prev;
  logic clock_input_is_clock, oscillator_enable, stop_mode;
  logic source_clock_out, half_rate_clock_out, external_engaged_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] src_edges, half_edges;
  cssw_pin_t port_bit_four, clock_output_pin;
  int num_errors, checked, cycles, run_len, min_w, ext_cnt, n;
  cssw_clock_source_switch dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .clock_input_pin, .port_bit_four, .clock_output_pin,
    .clock_input_is_clock, .oscillator_enable, .stop_mode, .monitor_bypass,
    .source_clock_out, .half_rate_clock_out, .external_engaged_flag);
  cssw_siu_model siu (.clk, .rst_n, .source_clock_out, .half_rate_clock_out,
    .halt_osc, .stop_req, .clear, .oscillator_enable, .stop_mode, .src_edges,
    .half_edges);
  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic in_rng(input logic [15:0] got, input int lo, input int hi, input string m);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s got %0d", $time, m, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp), m);
  endtask
  task automatic window(input int len);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (len) @(posedge clk);
    #1;
  endtask
  task automatic wait_src(input logic lvl);
    n = 0;
    while (source_clock_out !== lvl && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ********
  // clock, external source, glitch watch and hang limit
  // ********
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ext_run) begin
      ext_cnt <= (ext_cnt == 3) ? 0 : ext_cnt + 1;
      if (ext_cnt == 3) clock_input_pin <= ~clock_input_pin;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    src_prev <= source_clock_out;
    if (source_clock_out !== src_prev) begin
      if (track && armed && run_len < min_w) min_w <= run_len;
      armed <= track;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
    if (cycles == 60000) begin
      num_errors++;
      complete_run;
    end
  end
  // ********
  // main sequence
  // ********
  initial begin
    {rst_n, reg_wr, reg_rd, clock_input_pin, monitor_bypass} = '0;
    {halt_osc, stop_req, clear, ext_run, track, armed, src_prev} = '0;
    {reg_addr, reg_wdata, port_bit_four} = '0;
    {num_errors, checked, cycles, run_len, ext_cnt, n} = '0;
    min_w = 1000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CSSW_OFS_TRIM, `CSSW_TRIM_RST, "trim reset");
    rd(`CSSW_OFS_STATUS, 8'h00, "status reset");
    rd(8'h7F, 8'h00, "unmapped read");
    chk(16'(external_engaged_flag), 16'h0000, "engaged reset");
    $display("test reset done");
    wr(`CSSW_OFS_TRIM, 8'hFF);
    rd(`CSSW_OFS_TRIM, 8'hFF, "trim max");
    wr(`CSSW_OFS_TRIM, 8'h00);
    rd(`CSSW_OFS_TRIM, 8'h00, "trim min");
    repeat (300) @(posedge clk);
    window(4000);
    in_rng(src_edges, 124, 126, "trim 0 rate");
    in_rng(half_edges, 61, 64, "half rate");
    wr(`CSSW_OFS_TRIM, 8'h10);
    repeat (300) @(posedge clk);
    window(4000);
    in_rng(src_edges, 61, 64, "trim 16 rate");
    wr(`CSSW_OFS_TRIM, 8'h00);
    repeat (300) @(posedge clk);
    $display("test trim done");
    halt_osc <= 1'b1;
    window(400);
    chk(src_edges + half_edges, 16'h0000, "osc disabled");
    halt_osc <= 1'b0;
    stop_req <= 1'b1;
    window(400);
    chk(src_edges + half_edges, 16'h0000, "stop mode");
    stop_req <= 1'b0;
    window(400);
    in_rng(src_edges, 11, 14, "after stop");
    $display("test low power done");
    port_bit_four <= 2'b10;
    wr(`CSSW_OFS_OPTION, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(16'(clock_output_pin), 16'h0002, "int port");
    chk(16'(clock_input_is_clock), 16'h0000, "int input pin");
    for (int i = 4; i < 7; i += 2) begin
      wr(`CSSW_OFS_OPTION, 8'(i));
      wait_src(1'b1);
      chk(16'(clock_output_pin), 16'h0003, "pin clock high");
      wait_src(1'b0);
      chk(16'(clock_output_pin), 16'h0001, "pin clock low");
    end
    wr(`CSSW_OFS_OPTION, 8'h05);
    repeat (3) @(posedge clk);
    #1;
    chk(16'(clock_output_pin), 16'h0002, "ext port");
    chk(16'(clock_input_is_clock), 16'h0001, "ext input pin");
    port_bit_four <= 2'b11;
    wr(`CSSW_OFS_OPTION, 8'h03);
    repeat (3) @(posedge clk);
    #1;
    chk(16'(clock_output_pin), 16'h0003, "xtal low in");
    clock_input_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(clock_output_pin), 16'h0001, "xtal high in");
    clock_input_pin <= 1'b0;
    $display("test pin done");
    monitor_bypass <= 1'b1;
    wr(`CSSW_OFS_STATUS, 8'h01);
    rd(`CSSW_OFS_STATUS, 8'h00, "bypass request");
    monitor_bypass <= 1'b0;
    wr(`CSSW_OFS_OPTION, 8'h01);
    repeat (50) @(posedge clk);
    wr(`CSSW_OFS_STATUS, 8'h01);
    rd(`CSSW_OFS_STATUS, 8'h01, "request set");
    track <= 1'b1;
    clock_input_pin <= 1'b1;
    repeat (8) @(posedge clk);
    clock_input_pin <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chk(16'(external_engaged_flag), 16'h0000, "one edge only");
    ext_run <= 1'b1;
    n = 0;
    while (external_engaged_flag !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    in_rng(16'(n), 1, 199, "engage delay");
    rd(`CSSW_OFS_STATUS, 8'h03, "engaged");
    window(800);
    in_rng(src_edges, 99, 101, "ext rate");
    in_rng(half_edges, 49, 51, "ext half rate");
    track <= 1'b0;
    in_rng(16'(min_w), 4, 1000, "min pulse");
    ext_run <= 1'b0;
    window(300);
    chk(src_edges, 16'h0000, "no fallback");
    wr(`CSSW_OFS_STATUS, 8'h00);
    rd(`CSSW_OFS_STATUS, 8'h02, "engaged sticky");
    $display("test switch done");
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CSSW_OFS_STATUS, 8'h00, "status after reset");
    window(1000);
    in_rng(src_edges, 2, 4, "internal after reset");
    $display("test second reset done");
    complete_run;
  end
endmodule
